// ---- verilog/cmd_decoder_pkg.sv ----
`default_nettype none
package cmd_decoder_pkg;
    // Register map, byte addresses of aligned 32-bit words.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CMD_A = 8'h00;
    localparam logic [7:0] ADDR_CMD_B = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Position of the command code inside a command register write.
    localparam int CMD_HI = 7;
    localparam int CMD_LO = 4;
    localparam int CMD_LANE = 0;

    // Upper command codes handled here.
    localparam logic [3:0] CODE_RX_SET = 4'h8;
    localparam logic [3:0] CODE_RX_CLR = 4'h9;
    localparam logic [3:0] CODE_TX_SET = 4'hA;
    localparam logic [3:0] CODE_TX_CLR = 4'hB;
    localparam logic [3:0] CODE_STANDBY_OR_UNLATCH = 4'hC;
    localparam logic [3:0] CODE_ACTIVE_OR_CHAIN = 4'hD;
    localparam logic [3:0] CODE_RSVD_E = 4'hE;
    localparam logic [3:0] CODE_RSVD_F = 4'hF;

    // Status register field positions.
    localparam int ST_RX_EXT = 0;
    localparam int ST_TX_EXT = 2;
    localparam int ST_STANDBY = 4;
    localparam int ST_CHAIN_MODE = 5;
    localparam int ST_IN_SERVICE = 6;

    // Reset values of the control state.
    localparam logic RST_EXTEND = 1'b0;
    localparam logic RST_STANDBY = 1'b0;
    localparam logic RST_CHAIN_MODE = 1'b0;
    localparam logic RST_IN_SERVICE = 1'b0;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmd_decoder_pkg
`default_nettype wire

// ---- verilog/rate_extend_bits.sv ----
`timescale 1ns/1ns
`default_nettype none
module rate_extend_bits
    import cmd_decoder_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Decoded command for this channel.
    input wire logic cmd_go,
    input wire logic [3:0] cmd_code,
    // Extend bits.
    output logic rx_ext_ff,
    output logic tx_ext_ff
);
    logic nxt_rx_ext;
    logic nxt_tx_ext;

    // Set and clear codes touch only this channel's bits.
    always_comb begin
        nxt_rx_ext = rx_ext_ff;
        nxt_tx_ext = tx_ext_ff;
        if (cmd_go) begin
            case (cmd_code)
                CODE_RX_SET: nxt_rx_ext = 1'b1; // [R2]
                CODE_RX_CLR: nxt_rx_ext = 1'b0; // [R3]
                CODE_TX_SET: nxt_tx_ext = 1'b1; // [R4]
                CODE_TX_CLR: nxt_tx_ext = 1'b0; // [R5]
                default: ; // [R12]
            endcase
        end
    end

    // Registers the extend bits.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ext_ff <= RST_EXTEND;
            tx_ext_ff <= RST_EXTEND;
        end else begin
            rx_ext_ff <= nxt_rx_ext;
            tx_ext_ff <= nxt_tx_ext;
        end
    end
endmodule : rate_extend_bits
`default_nettype wire

// ---- verilog/channel_command_decoder_upper.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1: Command code is bits 7:4, per channel.
// R2: Code 1000 sets receive extend bit.
// R3: Code 1001 clears that channel's receive extend.
// R4: Code 1010 sets transmit extend bit.
// R5: Code 1011 clears transmit extend bit.
// R6: Code 1100 on channel A enters standby.
// R7: Standby leaves only by reset or active.
// R8: Code 1101 on channel A exits standby.
// R9: Code 1100 on B resets in-service latch.
// R10: Latch reset drives chain enable high.
// R11: Code 1101 on B enters chain mode.
// R12: Codes 1110 and 1111 change nothing.
module channel_command_decoder_upper
    import cmd_decoder_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address channel.
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    // AXI4-Lite write data channel.
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response channel.
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address channel.
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    // AXI4-Lite read data channel.
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Interrupt acknowledge from the chain logic, one-cycle pulse.
    input wire logic intr_ack,
    // Block state.
    output logic [CHANNELS-1:0] receive_rate_select_extend,
    output logic [CHANNELS-1:0] transmit_rate_select_extend,
    output logic standby_mode,
    output logic chain_mode,
    output logic interrupt_in_service_latch,
    output logic chain_enable_output
);
    logic aw_held_ff;
    logic nxt_aw_held;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [ADDR_W-1:0] nxt_aw_addr;
    logic w_held_ff;
    logic nxt_w_held;
    logic [31:0] w_data_ff;
    logic [31:0] nxt_w_data;
    logic [3:0] w_strb_ff;
    logic [3:0] nxt_w_strb;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;
    logic standby_ff;
    logic nxt_standby;
    logic chain_mode_ff;
    logic nxt_chain_mode;
    logic in_service_ff;
    logic nxt_in_service;
    logic commit;
    logic hit_a;
    logic hit_b;
    logic go_a;
    logic go_b;
    logic [3:0] cmd_code;
    logic [31:0] status_word;

    // Channel handshakes; a pending response blocks new writes.
    assign awready = !aw_held_ff && !bvalid_ff;
    assign wready = !w_held_ff && !bvalid_ff;
    assign arready = !rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    // A write executes once both its address and data are held.
    assign commit = aw_held_ff && w_held_ff && !bvalid_ff;
    assign hit_a = (aw_addr_ff == ADDR_CMD_A);
    assign hit_b = (aw_addr_ff == ADDR_CMD_B);
    assign cmd_code = w_data_ff[CMD_HI:CMD_LO]; // [R1]
    assign go_a = commit && hit_a && w_strb_ff[CMD_LANE]; // [R1]
    assign go_b = commit && hit_b && w_strb_ff[CMD_LANE]; // [R1]

    // Write channel capture and response.
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held = w_held_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (awvalid && awready) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w_held = 1'b1;
            nxt_w_data = wdata;
            nxt_w_strb = wstrb;
        end
        if (commit) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            if (hit_a || hit_b) begin
                nxt_bresp = RESP_OKAY;
            end else begin
                nxt_bresp = RESP_SLVERR;
            end
        end else if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // Status word seen by reads.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_RX_EXT +: CHANNELS] = receive_rate_select_extend;
        status_word[ST_TX_EXT +: CHANNELS] = transmit_rate_select_extend;
        status_word[ST_STANDBY] = standby_ff;
        status_word[ST_CHAIN_MODE] = chain_mode_ff;
        status_word[ST_IN_SERVICE] = in_service_ff;
    end

    // Read channel; command registers read as zero.
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (arvalid && arready) begin
            nxt_rvalid = 1'b1;
            if (araddr == ADDR_STATUS) begin
                nxt_rdata = status_word;
                nxt_rresp = RESP_OKAY;
            end else if (araddr == ADDR_CMD_A || araddr == ADDR_CMD_B) begin
                nxt_rdata = 32'h0000_0000;
                nxt_rresp = RESP_OKAY;
            end else begin
                nxt_rdata = 32'h0000_0000;
                nxt_rresp = RESP_SLVERR;
            end
        end else if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Chip-wide modes; reserved and lower codes fall through untouched.
    always_comb begin
        nxt_standby = standby_ff;
        nxt_chain_mode = chain_mode_ff;
        nxt_in_service = in_service_ff;
        if (go_a && cmd_code == CODE_STANDBY_OR_UNLATCH) begin
            nxt_standby = 1'b1; // [R6]
        end else if (go_a && cmd_code == CODE_ACTIVE_OR_CHAIN) begin
            nxt_standby = 1'b0; // [R7] [R8]
        end
        if (go_b && cmd_code == CODE_ACTIVE_OR_CHAIN) begin
            nxt_chain_mode = 1'b1; // [R11]
        end
        if (go_b && cmd_code == CODE_STANDBY_OR_UNLATCH && chain_mode_ff) begin
            nxt_in_service = 1'b0; // [R9]
        end
        // An acknowledge in the same cycle wins over the reset command.
        if (intr_ack && chain_mode_ff) begin
            nxt_in_service = 1'b1;
        end
    end

    // Registers all bus and mode state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
            standby_ff <= RST_STANDBY; // [R7]
            chain_mode_ff <= RST_CHAIN_MODE;
            in_service_ff <= RST_IN_SERVICE;
        end else begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff <= nxt_w_held;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            standby_ff <= nxt_standby;
            chain_mode_ff <= nxt_chain_mode;
            in_service_ff <= nxt_in_service;
        end
    end

    assign standby_mode = standby_ff;
    assign chain_mode = chain_mode_ff;
    assign interrupt_in_service_latch = in_service_ff;
    // Priority passes downstream whenever no interrupt is in service.
    assign chain_enable_output = !in_service_ff; // [R10]

    // One pair of extend bits per channel; channel 0 takes go_a and every other channel takes go_b.
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            rate_extend_bits u_bits (
                .aclk(aclk),
                .aresetn(aresetn),
                .cmd_go((ch == 0) ? go_a : go_b), // [R1]
                .cmd_code(cmd_code),
                .rx_ext_ff(receive_rate_select_extend[ch]),
                .tx_ext_ff(transmit_rate_select_extend[ch])
            );
        end
    endgenerate

    // Checks on the decoded behaviour.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence write_both_taken;
        awvalid && awready && wvalid && wready;
    endsequence

    write_resp_a: assert property (write_both_taken |=> ##1 bvalid)
        else $error("Write response did not follow a taken write.");
    read_resp_a: assert property (arvalid && arready |=> rvalid)
        else $error("Read data did not follow a taken read address.");
    rx_set_a: assert property (go_a && cmd_code == CODE_RX_SET // [R2]
        |=> receive_rate_select_extend[0])
        else $error("Receive extend bit A not set.");
    rx_clear_a: assert property (go_b && cmd_code == CODE_RX_CLR // [R3]
        |=> !receive_rate_select_extend[1]
        && receive_rate_select_extend[0] == $past(receive_rate_select_extend[0]))
        else $error("Receive extend clear touched the wrong channel.");
    tx_set_a: assert property (go_b && cmd_code == CODE_TX_SET // [R4]
        |=> transmit_rate_select_extend[1])
        else $error("Transmit extend bit B not set.");
    tx_clear_a: assert property (go_a && cmd_code == CODE_TX_CLR // [R5]
        |=> !transmit_rate_select_extend[0])
        else $error("Transmit extend bit A not cleared.");
    standby_enter_a: assert property (go_a && cmd_code == CODE_STANDBY_OR_UNLATCH // [R6]
        |=> standby_mode)
        else $error("Standby not entered.");
    // A reset of a single cycle may also end standby, so the edge after it is allowed.
    standby_exit_a: assert property ($fell(standby_mode) // [R7]
        |-> !$past(aresetn)
        || ($past(go_a) && $past(cmd_code) == CODE_ACTIVE_OR_CHAIN))
        else $error("Standby left without reset or the active command.");
    active_mode_a: assert property (go_a && cmd_code == CODE_ACTIVE_OR_CHAIN // [R8]
        |=> !standby_mode)
        else $error("Active command did not leave standby.");
    unlatch_a: assert property (go_b && cmd_code == CODE_STANDBY_OR_UNLATCH // [R9]
        && chain_mode && !intr_ack |=> !interrupt_in_service_latch)
        else $error("In-service latch not reset.");
    chain_out_a: assert property (go_b && cmd_code == CODE_STANDBY_OR_UNLATCH // [R10]
        && chain_mode && !intr_ack |=> chain_enable_output)
        else $error("Chain enable not high after latch reset.");
    // An acknowledge in chain mode sets the latch, even against the reset command.
    ack_set_a: assert property (intr_ack && chain_mode |=> interrupt_in_service_latch)
        else $error("Acknowledge did not set the in-service latch.");
    chain_enter_a: assert property (go_b && cmd_code == CODE_ACTIVE_OR_CHAIN // [R11]
        |=> chain_mode)
        else $error("Chain mode not entered.");
    reserved_a: assert property ((go_a || go_b) && cmd_code[3:1] == CODE_RSVD_E[3:1] // [R12]
        && !intr_ack |=> $stable(standby_mode) && $stable(chain_mode)
        && $stable(interrupt_in_service_latch)
        && $stable(receive_rate_select_extend)
        && $stable(transmit_rate_select_extend))
        else $error("Reserved code changed state.");
endmodule : channel_command_decoder_upper
`default_nettype wire

// ---- tb/host_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
    import cmd_decoder_pkg::*;
(
    // Clock.
    input wire logic aclk,
    // Write channels.
    output var logic awvalid,
    input wire logic awready,
    output var logic [ADDR_W-1:0] awaddr,
    output var logic wvalid,
    input wire logic wready,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    input wire logic bvalid,
    output var logic bready,
    input wire logic [1:0] bresp,
    // Read channels.
    output var logic arvalid,
    input wire logic arready,
    output var logic [ADDR_W-1:0] araddr,
    input wire logic rvalid,
    output var logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    // Idle bus at time zero.
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
    end

    // One write; a released address or data shows its inverse so stale values are never reused.
    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                              input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : write_word

    // One read, held until the data beat is taken.
    task automatic read_word(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                             output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : read_word
endmodule : host_bus_model
`default_nettype wire

// ---- tb/test_channel_command_decoder_upper.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_channel_command_decoder_upper
    import cmd_decoder_pkg::*;
();
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic intr_ack = 1'b0;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr, rx_ext, tx_ext, exp_rx, exp_tx;
    logic standby_mode, chain_mode, interrupt_in_service_latch, chain_enable_output;
    logic exp_sb, exp_cm, exp_latch;
    int failures = 0;
    int check_count = 0;
    // Bit 5 asks for an acknowledge pulse, bit 4 picks channel B, bits 3:0 the code.
    localparam logic [5:0] OPS [27] = '{6'h08, 6'h1A, 6'h0A, 6'h18, 6'h09, 6'h1B, 6'h0E,
        6'h1F, 6'h07, 6'h17, 6'h1C, 6'h20, 6'h0C, 6'h0F, 6'h1C, 6'h0D, 6'h1D, 6'h20, 6'h1E,
        6'h0C, 6'h1C, 6'h20, 6'h1D, 6'h1C, 6'h0D, 6'h0B, 6'h19};

    channel_command_decoder_upper #(.CHANNELS(2)) channel_command_decoder_upper_inst (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .intr_ack(intr_ack),
        .receive_rate_select_extend(rx_ext), .transmit_rate_select_extend(tx_ext),
        .standby_mode(standby_mode), .chain_mode(chain_mode),
        .interrupt_in_service_latch(interrupt_in_service_latch),
        .chain_enable_output(chain_enable_output));

    host_bus_model host_bus_model_inst (
        .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    // Clock of 100 ns period.
    always #50 aclk = ~aclk;

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // Compares status word and state pins with the expected state.
    task automatic check_state();
        host_bus_model_inst.read_word(ADDR_STATUS, rd, rr);
        check("status", {25'h0, exp_latch, exp_cm, exp_sb, exp_tx, exp_rx}, rd);
        check("pins", {25'h0, exp_latch, exp_cm, exp_sb, exp_tx, exp_rx}, {25'h0,
            interrupt_in_service_latch, chain_mode, standby_mode, tx_ext, rx_ext});
        check("chain_enable", {31'h0, ~exp_latch}, {31'h0, chain_enable_output});
    endtask : check_state

    // Issues one operation and updates the expected state by the command rules.
    task automatic run_op(input logic [5:0] op);
        if (op[5]) begin
            @(posedge aclk);
            intr_ack <= 1'b1;
            @(posedge aclk);
            intr_ack <= 1'b0;
            exp_latch = exp_latch | exp_cm;
        end else begin
            host_bus_model_inst.write_word(op[4] ? ADDR_CMD_B : ADDR_CMD_A,
                {24'hC3A55A, op[3:0], 4'h6}, 4'hF, rr);
            check("bresp", {30'h0, RESP_OKAY}, {30'h0, rr});
            case (op[3:0])
                CODE_RX_SET: exp_rx[op[4]] = 1'b1;
                CODE_RX_CLR: exp_rx[op[4]] = 1'b0;
                CODE_TX_SET: exp_tx[op[4]] = 1'b1;
                CODE_TX_CLR: exp_tx[op[4]] = 1'b0;
                CODE_STANDBY_OR_UNLATCH: begin
                    if (!op[4]) exp_sb = 1'b1;
                    else if (exp_cm) exp_latch = 1'b0;
                end
                CODE_ACTIVE_OR_CHAIN: begin
                    if (!op[4]) exp_sb = 1'b0;
                    else exp_cm = 1'b1;
                end
                default: ;
            endcase
        end
    endtask : run_op

    // Watchdog well beyond the expected run length.
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        complete_run();
    end

    // Main sequence; reset is held for three cycles at the start.
    initial begin
        {exp_rx, exp_tx, exp_sb, exp_cm, exp_latch} = 7'h00;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check_state();
        $display("test reset done");
        foreach (OPS[i]) begin
            run_op(OPS[i]);
            check_state();
        end
        $display("test commands done");
        host_bus_model_inst.read_word(ADDR_CMD_A, rd, rr);
        check("cmd read", 32'h0, rd);
        check("cmd rresp", {30'h0, RESP_OKAY}, {30'h0, rr});
        host_bus_model_inst.read_word(8'h0C, rd, rr);
        check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
        host_bus_model_inst.write_word(8'h0C, {24'h0, CODE_RX_SET, 4'h0}, 4'hF, rr);
        check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
        host_bus_model_inst.write_word(ADDR_STATUS, 32'h0000007F, 4'hF, rr);
        check("status bresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
        host_bus_model_inst.write_word(ADDR_CMD_A, {24'h0, CODE_RX_SET, 4'h0}, 4'hE, rr);
        check("strobe bresp", {30'h0, RESP_OKAY}, {30'h0, rr});
        check_state();
        $display("test bus done");
        // Builds up state, then a one-cycle reset in mid-run must clear all of it.
        run_op(6'h08);
        run_op(6'h1A);
        run_op(6'h0C);
        run_op(6'h20);
        check_state();
        @(posedge aclk);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        {exp_rx, exp_tx, exp_sb, exp_cm, exp_latch} = 7'h00;
        check_state();
        $display("test reset again done");
        complete_run();
    end
endmodule : test_channel_command_decoder_upper
`default_nettype wire
